//--- rtl/pfm_pkg.sv
package pfm_pkg;
   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int PIN_NUM  = 30;
   localparam int RAW_PINS = 8;
   localparam int FUNC_NUM = 4;
   localparam int FIDX_W   = 2;
   localparam int ADDR_W   = 12;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [11:0] STATUS_OFS   = 12'h000;
   localparam logic [11:0] CTRL_OFS     = 12'h004;
   localparam logic [11:0] RAW_OFS      = 12'h0f0;
   localparam logic [11:0] EVT_STAT_OFS = 12'h200;
   localparam logic [11:0] EVT_MASK_OFS = 12'h204;

   // ------------------------------------------------------------
   // Control fields, status bits and reset values
   // ------------------------------------------------------------
   localparam int FSEL_LSB    = 0;
   localparam int OUT_OVR_LSB = 8;
   localparam int OE_OVR_LSB  = 12;
   localparam int IN_OVR_LSB  = 16;
   localparam int IRQ_OVR_LSB = 28;
   localparam int ST_OUT_SRC  = 8;
   localparam int ST_OUT_APP  = 9;
   localparam int ST_OE_SRC   = 12;
   localparam int ST_OE_APP   = 13;
   localparam int ST_IN_RAW   = 17;
   localparam int ST_IN_APP   = 19;
   localparam int ST_IRQ_SRC  = 24;
   localparam int ST_IRQ_APP  = 26;
   localparam logic [4:0]  FSEL_NULL  = 5'h1f;
   localparam logic [31:0] CTRL_RST   = 32'h0000_001f;
   localparam logic [31:0] CTRL_WMASK = 32'h3003_331f;
   localparam logic [7:0]  EVT_RST    = 8'h00;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // Override selector encoding shared by all four paths.
   typedef enum logic [1:0] {OVR_PASS, OVR_INVERT, OVR_LOW, OVR_HIGH} pfm_ovr_t;

   // Applies one override selector to a signal.
   function automatic logic pfm_apply(input logic [1:0] sel, input logic v);
      unique case (pfm_ovr_t'(sel))
         OVR_PASS:   pfm_apply = v;
         OVR_INVERT: pfm_apply = ~v;
         OVR_LOW:    pfm_apply = 1'b0;
         OVR_HIGH:   pfm_apply = 1'b1;
      endcase
   endfunction
endpackage

//--- rtl/pfm_reg_if.sv
`timescale 1ns/10ps
// Register access strobes between the bus slave and the register file.
interface pfm_reg_if;
   logic        wr;
   logic        rd;
   logic [11:0] waddr;
   logic [11:0] raddr;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic [31:0] rdata;
   logic        wok;
   logic        rok;
   modport slv  (output wr, rd, waddr, raddr, wdata, wstrb, input rdata, wok, rok);
   modport regs (input wr, rd, waddr, raddr, wdata, wstrb, output rdata, wok, rok);
endinterface

//--- rtl/pfm_axil_slv.sv
`timescale 1ns/10ps
module pfm_axil_slv
   import pfm_pkg::*;
(
   input  wire logic              clk,       // Core clock.
   input  wire logic              rst_n,     // Async reset, active low.
   input  wire logic [ADDR_W-1:0] awaddr,    // Write address.
   input  wire logic              awvalid,   // Write address valid.
   output logic                   awready,   // Write address ready.
   input  wire logic [31:0]       wdata,     // Write data.
   input  wire logic [3:0]        wstrb,     // Write byte strobes.
   input  wire logic              wvalid,    // Write data valid.
   output logic                   wready,    // Write data ready.
   output logic [1:0]             bresp,     // Write response.
   output logic                   bvalid,    // Write response valid.
   input  wire logic              bready,    // Write response ready.
   input  wire logic [ADDR_W-1:0] araddr,    // Read address.
   input  wire logic              arvalid,   // Read address valid.
   output logic                   arready,   // Read address ready.
   output logic [31:0]            rdata,     // Read data.
   output logic [1:0]             rresp,     // Read response.
   output logic                   rvalid,    // Read data valid.
   input  wire logic              rready,    // Read data ready.
   pfm_reg_if.slv                 rb         // Register strobes.
);
   logic aw_held_ff;
   logic w_held_ff;

   // ------------------------------------------------------------
   // Strobes towards the register file
   // ------------------------------------------------------------
   assign rb.wr = aw_held_ff & w_held_ff & ~bvalid;
   assign rb.rd = arvalid & arready;
   assign rb.raddr = araddr;

   // Address and data are captured in either order and held.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awready    <= 1'b1;
         wready     <= 1'b1;
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         rb.waddr   <= '0;
         rb.wdata   <= '0;
         rb.wstrb   <= '0;
      end else begin
         if (awvalid && awready) begin
            awready    <= 1'b0;
            aw_held_ff <= 1'b1;
            rb.waddr   <= awaddr;
         end
         if (wvalid && wready) begin
            wready    <= 1'b0;
            w_held_ff <= 1'b1;
            rb.wdata  <= wdata;
            rb.wstrb  <= wstrb;
         end
         if (rb.wr) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
         end
         if (bvalid && bready) begin
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // Write response follows the register write by one cycle.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (rb.wr) begin
         bvalid <= 1'b1;
         bresp  <= rb.wok ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Read data is registered in the cycle the address is taken.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else if (rb.rd) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rb.rdata;
         rresp   <= rb.rok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
      end
   end
endmodule

//--- rtl/pfm_pin_mux.sv
`timescale 1ns/10ps
module pfm_pin_mux
   import pfm_pkg::*;
(
   input  wire logic                              CORE_CLK,        // Core clock.
   input  wire logic                              RST_N,           // Async reset, active low.
   input  wire logic [ADDR_W-1:0]                 S_AXI_AWADDR,    // Write address.
   input  wire logic                              S_AXI_AWVALID,   // Write address valid.
   output logic                                   S_AXI_AWREADY,   // Write address ready.
   input  wire logic [31:0]                       S_AXI_WDATA,     // Write data.
   input  wire logic [3:0]                        S_AXI_WSTRB,     // Write strobes.
   input  wire logic                              S_AXI_WVALID,    // Write data valid.
   output logic                                   S_AXI_WREADY,    // Write data ready.
   output logic [1:0]                             S_AXI_BRESP,     // Write response.
   output logic                                   S_AXI_BVALID,    // Write response valid.
   input  wire logic                              S_AXI_BREADY,    // Write response ready.
   input  wire logic [ADDR_W-1:0]                 S_AXI_ARADDR,    // Read address.
   input  wire logic                              S_AXI_ARVALID,   // Read address valid.
   output logic                                   S_AXI_ARREADY,   // Read address ready.
   output logic [31:0]                            S_AXI_RDATA,     // Read data.
   output logic [1:0]                             S_AXI_RRESP,     // Read response.
   output logic                                   S_AXI_RVALID,    // Read data valid.
   input  wire logic                              S_AXI_RREADY,    // Read data ready.
   input  wire logic [PIN_NUM-1:0]                PAD_IN,          // Pin input levels.
   output logic      [PIN_NUM-1:0]                PAD_OUT,         // Pin output levels.
   output logic      [PIN_NUM-1:0]                PAD_OE,          // Pin driver enables.
   input  wire logic [FUNC_NUM-1:0][PIN_NUM-1:0]  SRC_OUT,         // Function outputs.
   input  wire logic [FUNC_NUM-1:0][PIN_NUM-1:0]  SRC_OE,          // Function enables.
   output logic      [FUNC_NUM-1:0][PIN_NUM-1:0]  SRC_IN,          // Inputs to functions.
   output logic      [PIN_NUM-1:0]                IRQ_TO_PROC,     // Pin interrupts out.
   output logic                                   IRQ              // Event interrupt.
);
   pfm_reg_if rb ();

   logic [31:0]          ctrl_ff [PIN_NUM];
   logic [31:0]          status_w [PIN_NUM];
   logic [PIN_NUM-1:0]   pad_s1_ff;
   logic [PIN_NUM-1:0]   pad_s2_ff;
   logic [PIN_NUM-1:0]   in_app_ff;
   logic [PIN_NUM-1:0]   out_src;
   logic [PIN_NUM-1:0]   oe_src;
   logic [PIN_NUM-1:0]   irq_src;
   logic [PIN_NUM-1:0]   nxt_out;
   logic [PIN_NUM-1:0]   nxt_oe;
   logic [PIN_NUM-1:0]   nxt_in;
   logic [PIN_NUM-1:0]   nxt_irq;
   logic [RAW_PINS-1:0]  prev_ff;
   logic [RAW_PINS-1:0]  lvl_hi_ff;
   logic [RAW_PINS-1:0]  lvl_lo_ff;
   logic [RAW_PINS-1:0]  rise_ff;
   logic [RAW_PINS-1:0]  fall_ff;
   logic [RAW_PINS-1:0]  rise_det;
   logic [RAW_PINS-1:0]  fall_det;
   logic [RAW_PINS-1:0]  rise_clr;
   logic [RAW_PINS-1:0]  fall_clr;
   logic [31:0]          raw_w;
   logic [7:0]           evt_stat_ff;
   logic [7:0]           evt_mask_ff;
   logic [4:0]           widx;
   logic [4:0]           ridx;
   logic                 w_pin;
   logic                 r_pin;
   logic                 w_raw;
   logic [31:0]          strb_mask;

   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   pfm_axil_slv u_slv (
      .clk     (CORE_CLK),
      .rst_n   (RST_N),
      .awaddr  (S_AXI_AWADDR),
      .awvalid (S_AXI_AWVALID),
      .awready (S_AXI_AWREADY),
      .wdata   (S_AXI_WDATA),
      .wstrb   (S_AXI_WSTRB),
      .wvalid  (S_AXI_WVALID),
      .wready  (S_AXI_WREADY),
      .bresp   (S_AXI_BRESP),
      .bvalid  (S_AXI_BVALID),
      .bready  (S_AXI_BREADY),
      .araddr  (S_AXI_ARADDR),
      .arvalid (S_AXI_ARVALID),
      .arready (S_AXI_ARREADY),
      .rdata   (S_AXI_RDATA),
      .rresp   (S_AXI_RRESP),
      .rvalid  (S_AXI_RVALID),
      .rready  (S_AXI_RREADY),
      .rb      (rb)
   );

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   // Per-pin words sit in pairs below the raw interrupt word.
   assign widx = rb.waddr[7:3];
   assign ridx = rb.raddr[7:3];
   assign w_pin = (rb.waddr < RAW_OFS) && (rb.waddr[1:0] == 2'h0);
   assign r_pin = (rb.raddr < RAW_OFS) && (rb.raddr[1:0] == 2'h0);
   assign w_raw = rb.wr && (rb.waddr == RAW_OFS);
   assign strb_mask = {{8{rb.wstrb[3]}}, {8{rb.wstrb[2]}}, {8{rb.wstrb[1]}}, {8{rb.wstrb[0]}}};
   assign rb.wok = w_pin || (rb.waddr == RAW_OFS) || (rb.waddr == EVT_STAT_OFS)
                   || (rb.waddr == EVT_MASK_OFS);
   assign rb.rok = r_pin || (rb.raddr == RAW_OFS) || (rb.raddr == EVT_STAT_OFS)
                   || (rb.raddr == EVT_MASK_OFS);

   // Read data mux; unmapped addresses read zero.
   always_comb begin
      rb.rdata = '0;
      if (r_pin) begin
         rb.rdata = rb.raddr[2] ? ctrl_ff[ridx] : status_w[ridx];
      end else if (rb.raddr == RAW_OFS) begin
         rb.rdata = raw_w;
      end else if (rb.raddr == EVT_STAT_OFS) begin
         rb.rdata = {24'h0, evt_stat_ff};
      end else if (rb.raddr == EVT_MASK_OFS) begin
         rb.rdata = {24'h0, evt_mask_ff};
      end
   end

   // ------------------------------------------------------------
   // Pin input synchronisers
   // ------------------------------------------------------------
   // Two stages before any logic looks at the pin levels.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pad_s1_ff <= '0;
         pad_s2_ff <= '0;
      end else begin
         pad_s1_ff <= PAD_IN;
         pad_s2_ff <= pad_s1_ff;
      end
   end

   // ------------------------------------------------------------
   // Per-pin control, selection and overrides
   // ------------------------------------------------------------
   generate
      for (genvar n = 0; n < PIN_NUM; n++) begin : g_pin
         logic [4:0] fsel;
         logic       fvalid;
         assign fsel   = ctrl_ff[n][FSEL_LSB +: 5];
         assign fvalid = (fsel != FSEL_NULL) && (fsel < 5'(FUNC_NUM));

         always_ff @(posedge CORE_CLK or negedge RST_N) begin
            if (!RST_N) begin
               ctrl_ff[n] <= CTRL_RST;
            end else if (rb.wr && w_pin && rb.waddr[2] && (widx == 5'(n))) begin
               ctrl_ff[n] <= (ctrl_ff[n] & ~(CTRL_WMASK & strb_mask))
                             | (rb.wdata & CTRL_WMASK & strb_mask);
            end
         end

         assign out_src[n] = fvalid ? SRC_OUT[fsel[FIDX_W-1:0]][n] : 1'b0;
         assign oe_src[n]  = fvalid ? SRC_OE[fsel[FIDX_W-1:0]][n] : 1'b0;
         assign nxt_out[n] = pfm_apply(ctrl_ff[n][OUT_OVR_LSB +: 2], out_src[n]);
         assign nxt_oe[n]  = pfm_apply(ctrl_ff[n][OE_OVR_LSB +: 2], oe_src[n]);
         assign nxt_in[n]  = pfm_apply(ctrl_ff[n][IN_OVR_LSB +: 2], pad_s2_ff[n]);
         assign nxt_irq[n] = pfm_apply(ctrl_ff[n][IRQ_OVR_LSB +: 2], irq_src[n]);

         // forced high check, watched on every pin.
         property p_irq_high;
            @(posedge CORE_CLK) disable iff (!RST_N)
            ctrl_ff[n][IRQ_OVR_LSB +: 2] == 2'h3 |=> IRQ_TO_PROC[n];
         endproperty
         a_irq_high: assert property (p_irq_high) else $error("interrupt not high");

         // Only the raw pins carry an interrupt source.
         if (n < RAW_PINS) begin : g_irq
            assign irq_src[n] = rise_ff[n] | fall_ff[n];
         end else begin : g_noirq
            assign irq_src[n] = 1'b0;
         end

         // Input goes only to the selected function.
         for (genvar f = 0; f < FUNC_NUM; f++) begin : g_fn
            always_ff @(posedge CORE_CLK or negedge RST_N) begin
               if (!RST_N) begin
                  SRC_IN[f][n] <= 1'b0;
               end else begin
                  SRC_IN[f][n] <= nxt_in[n] && (fsel == 5'(f));
               end
            end
         end

         always_comb begin
            status_w[n] = '0;
            status_w[n][ST_OUT_SRC] = out_src[n];
            status_w[n][ST_OUT_APP] = PAD_OUT[n];
            status_w[n][ST_OE_SRC]  = oe_src[n];
            status_w[n][ST_OE_APP]  = PAD_OE[n];
            status_w[n][ST_IN_RAW]  = pad_s2_ff[n];
            status_w[n][ST_IN_APP]  = in_app_ff[n];
            status_w[n][ST_IRQ_SRC] = irq_src[n];
            status_w[n][ST_IRQ_APP] = IRQ_TO_PROC[n];
         end
      end
   endgenerate

   // Registered pin-side and interrupt outputs.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         PAD_OUT     <= '0;
         PAD_OE      <= '0;
         in_app_ff   <= '0;
         IRQ_TO_PROC <= '0;
      end else begin
         PAD_OUT     <= nxt_out;
         PAD_OE      <= nxt_oe;
         in_app_ff   <= nxt_in;
         IRQ_TO_PROC <= nxt_irq;
      end
   end

   // ------------------------------------------------------------
   // Raw interrupt word
   // ------------------------------------------------------------
   generate
      for (genvar n = 0; n < RAW_PINS; n++) begin : g_raw
         assign rise_det[n] = pad_s2_ff[n] & ~prev_ff[n];
         assign fall_det[n] = ~pad_s2_ff[n] & prev_ff[n];
         assign rise_clr[n] = w_raw && rb.wdata[4*n+3] && strb_mask[4*n+3];
         assign fall_clr[n] = w_raw && rb.wdata[4*n+2] && strb_mask[4*n+2];
         assign raw_w[4*n +: 4] = {rise_ff[n], fall_ff[n], lvl_hi_ff[n], lvl_lo_ff[n]};
      end
   endgenerate

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         prev_ff   <= '0;
         lvl_hi_ff <= '0;
         lvl_lo_ff <= '0;
      end else begin
         prev_ff   <= pad_s2_ff[RAW_PINS-1:0];
         lvl_hi_ff <= pad_s2_ff[RAW_PINS-1:0];
         lvl_lo_ff <= ~pad_s2_ff[RAW_PINS-1:0];
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rise_ff <= '0;
         fall_ff <= '0;
      end else begin
         rise_ff <= (rise_ff & ~rise_clr) | rise_det;
         fall_ff <= (fall_ff & ~fall_clr) | fall_det;
      end
   end

   // ------------------------------------------------------------
   // Event interrupt
   // ------------------------------------------------------------
   // Any edge on a raw pin is an event; reading the status clears it.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         evt_stat_ff <= EVT_RST;
      end else begin
         evt_stat_ff <= (rb.rd && rb.raddr == EVT_STAT_OFS ? EVT_RST : evt_stat_ff)
                        | rise_det | fall_det;
      end
   end

   // Mask register and the interrupt level.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         evt_mask_ff <= EVT_RST;
         IRQ         <= 1'b0;
      end else begin
         if (rb.wr && rb.waddr == EVT_MASK_OFS && rb.wstrb[0]) begin
            evt_mask_ff <= rb.wdata[7:0];
         end
         IRQ <= |(evt_stat_ff & evt_mask_ff);
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_null_sel;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (ctrl_ff[0][4:0] == FSEL_NULL && ctrl_ff[0][9:8] == 2'h0) |=> !PAD_OUT[0];
   endproperty
   a_null_sel: assert property (p_null_sel) else $error("null select drove output");

   property p_out_high;
      @(posedge CORE_CLK) disable iff (!RST_N)
      ctrl_ff[0][9:8] == 2'h3 |=> PAD_OUT[0];
   endproperty
   a_out_high: assert property (p_out_high) else $error("output not forced high");

   property p_out_inv;
      @(posedge CORE_CLK) disable iff (!RST_N)
      ctrl_ff[0][9:8] == 2'h1 |=> PAD_OUT[0] == !$past(out_src[0]);
   endproperty
   a_out_inv: assert property (p_out_inv) else $error("output not inverted");

   property p_oe_off;
      @(posedge CORE_CLK) disable iff (!RST_N)
      ctrl_ff[0][13:12] == 2'h2 |=> !PAD_OE[0];
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("driver not disabled");

   property p_in_pass;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (ctrl_ff[0][17:16] == 2'h0 && ctrl_ff[0][4:0] == 5'h0) |=> SRC_IN[0][0] == $past(pad_s2_ff[0]);
   endproperty
   a_in_pass: assert property (p_in_pass) else $error("input not passed");

   property p_rise_set;
      @(posedge CORE_CLK) disable iff (!RST_N)
      rise_det[0] |=> rise_ff[0] && evt_stat_ff[0];
   endproperty
   a_rise_set: assert property (p_rise_set) else $error("rising edge lost");

   property p_rise_clr;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (rise_clr[0] && !rise_det[0]) |=> !rise_ff[0];
   endproperty
   a_rise_clr: assert property (p_rise_clr) else $error("edge flag not cleared");

   c_raw_write: cover property (@(posedge CORE_CLK) disable iff (!RST_N) w_raw && rise_ff[0]);
   c_irq_out: cover property (@(posedge CORE_CLK) disable iff (!RST_N) $rose(IRQ));
   c_invert: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
      ctrl_ff[0][9:8] == 2'h1 ##1 PAD_OUT[0]);
endmodule

//--- tb/pfm_peri_model.sv
`timescale 1ns/10ps
// Far side: function 0 source plus pads with outside levels.
module pfm_peri_model
   import pfm_pkg::*;
(
   input  wire logic [PIN_NUM-1:0]               ext,   // Outside levels.
   input  wire logic [PIN_NUM-1:0]               so,    // Function 0 out and enable.
   input  wire logic [PIN_NUM-1:0]               pout,  // Pin output.
   input  wire logic [PIN_NUM-1:0]               poe,   // Pin driver enable.
   output logic      [PIN_NUM-1:0]               pin,   // Pin level seen.
   output logic      [FUNC_NUM-1:0][PIN_NUM-1:0] s_out, // Function outputs.
   output logic      [FUNC_NUM-1:0][PIN_NUM-1:0] s_oe   // Function enables.
);
   // A driven pin shows the driven level; functions 1 to 3 stay silent.
   assign pin   = (poe & pout) | (~poe & ext);
   assign s_out = {{(FUNC_NUM-1)*PIN_NUM{1'b0}}, so};
   assign s_oe  = {{(FUNC_NUM-1)*PIN_NUM{1'b0}}, so};
endmodule

//--- tb/pfm_pin_mux_tb.sv
`timescale 1ns/10ps
module pfm_pin_mux_tb;
   import pfm_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, irq;
   logic [11:0] awa = '0, ara = '0;
   logic [31:0] wd = '0, rdat, d;
   logic [1:0]  bresp, rresp, rs;
   logic        awv = 0, awr, wv = 0, wr_r, bv, brdy = 0, arv = 0, arr, rv, rrdy = 0;
   logic [PIN_NUM-1:0] ext = '0, so = 30'h1, pin, pout, poe, irqp;
   logic [FUNC_NUM-1:0][PIN_NUM-1:0] s_out, s_oe, s_in;
   int          n_errors = 0, comparisons = 0;
   pfm_pin_mux u_dut (.CORE_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wr_r), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy),
      .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy), .PAD_IN(pin),
      .PAD_OUT(pout), .PAD_OE(poe), .SRC_OUT(s_out), .SRC_OE(s_oe), .SRC_IN(s_in),
      .IRQ_TO_PROC(irqp), .IRQ(irq));
   pfm_peri_model u_peri (.ext(ext), .so(so), .pout(pout), .poe(poe), .pin(pin),
      .s_out(s_out), .s_oe(s_oe));
   // Clock at 100 MHz.
   always #5 clk = ~clk;
   // Compares one word and counts it.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Bus write: both channels offered, each released once taken.
   task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] r);
      awa <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      do begin
         @(posedge clk);
         if (awr === 1'b1) awv <= 1'b0;
         if (wr_r === 1'b1) wv <= 1'b0;
      end while (awv || wv);
      brdy <= 1'b1;
      do @(posedge clk); while (bv !== 1'b1);
      r = bresp;
      brdy <= 1'b0;
   endtask
   // Bus read.
   task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
      ara <= a;
      arv <= 1'b1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      rrdy <= 1'b1;
      do @(posedge clk); while (rv !== 1'b1);
      v = rdat;
      r = rresp;
      rrdy <= 1'b0;
   endtask
   // Sweeps every override code over all four paths.
   task automatic t_ovr();
      logic [31:0] c;
      logic        e;
      logic        s;
      ext <= 30'h2;
      rd(12'h0ec, d, rs);
      chk(d, 32'h1f);
      // Each code is tried with the out, enable and input sources low and then high.
      for (int k = 0; k < 8; k++) begin
         c = 32'(k % 4);
         s = (k >= 4);
         e = (c == 0 && s) || (c == 1 && !s) || (c == 3);
         so[0] <= s;
         ext[1] <= s;
         wr(CTRL_OFS, (c << 12) | (c << 8), rs);
         wr(12'h00c, c << 16, rs);
         wr(12'h014, (c << 28) | 32'h1f, rs);
         rd(STATUS_OFS, d, rs);
         chk(d & 32'h3300, {18'h0, e, s, 2'h0, e, s, 8'h0});
         chk({poe[0], pout[0]}, {e, e});
         rd(12'h008, d, rs);
         chk(d & 32'h000a_0000, {12'h0, e, 1'b0, s, 17'h0});
         chk(s_in[0][1], e);
         rd(12'h010, d, rs);
         chk(d & 32'h0500_0000, {c[0], 26'h0});
         chk(irqp[2], c[0]);
      end
   endtask
   // Toggles pin 3, clears its flags, then reads an unmapped place.
   task automatic t_edge();
      wr(EVT_MASK_OFS, 32'h08, rs);
      chk(rs, RESP_OKAY);
      ext[3] <= 1'b1;
      repeat (6) @(posedge clk);
      chk(irq, 1'b1);
      rd(RAW_OFS, d, rs);
      chk(d[15:12], 4'ha);
      ext[3] <= 1'b0;
      repeat (6) @(posedge clk);
      rd(RAW_OFS, d, rs);
      chk(d[15:12], 4'hd);
      wr(RAW_OFS, 32'h0000_f00f, rs);
      rd(RAW_OFS, d, rs);
      chk(d[15:12], 4'h1);
      chk(d[3:0], 4'h2);
      rd(EVT_STAT_OFS, d, rs);
      chk(d[3], 1'b1);
      repeat (3) @(posedge clk);
      chk(irq, 1'b0);
      rd(12'h300, d, rs);
      chk(rs, RESP_SLVERR);
      wr(12'h300, 32'h0, rs);
      chk(rs, RESP_SLVERR);
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Reset for 16 cycles, then the scenarios.
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_ovr();
      t_edge();
      print_verdict();
   end
   // Watchdog.
   initial begin
      #20us;
      n_errors++;
      print_verdict();
   end
endmodule
